// File: logic/diff_output_stop_control.sv
// differential output halt controller: stops, parks and restarts output pairs
// assumes output_halt_n and the pair settings are synchronous to clk_sys,
// and that clk_sys is the reference clock and keeps running while halting
`timescale 1ns/1ps
`default_nettype none

module diff_output_stop_control
  import halt_ctrl_pkg::*;
#(
  parameter int unsigned NUM_PAIRS = NUM_PAIRS_DEF,     // output pairs
  parameter logic [HALF_CNT_W-1:0] HALF_PERIOD = HALF_CNT_W'(HALF_PERIOD_DEF) // half period
)
(
  input wire logic clk_sys,                           // reference clock
  input wire logic arst_n,                            // async reset, active low
  input wire logic output_halt_n,                     // halt request, active low
  input wire logic park_mode,                         // 0 driven park, 1 undriven
  input wire logic [NUM_PAIRS-1:0] pair_stoppable,    // 1 stoppable, 0 free-run
  output clk_pair_pins_t [NUM_PAIRS-1:0] pair_pins,   // output pair pins
  output logic halted                                 // accepted halt level
);

  logic [HALF_CNT_W-1:0] half_cnt_reg; // cycles into current half period
  logic phase_reg;                     // internal clock phase, 1 = true high
  logic half_end;                      // last cycle of a half period
  logic rise_evt;                      // true output about to rise
  logic comp_rise;                     // complement output about to rise
  logic phase_next;                    // phase after this edge
  logic [DEBOUNCE_EDGES-1:0] samp_reg; // halt samples on complement edges
  logic halt_acc_reg;                  // debounced halt level, active low
  halt_state_t state_reg;              // sequencing state
  logic [2:0] restart_cnt_reg;         // output periods left before resume
  logic restart_done;                  // waited long enough to resume

  assign half_end = (half_cnt_reg == HALF_PERIOD - HALF_CNT_W'(1));
  assign rise_evt = half_end && !phase_reg;
  assign comp_rise = half_end && phase_reg;
  assign phase_next = half_end ? ~phase_reg : phase_reg;
  assign restart_done = (restart_cnt_reg == 3'h0);

  // free-running output clock generator; needs a live reference clock
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      half_cnt_reg <= '0;
      phase_reg <= 1'b0;
    end
    else
    begin
      half_cnt_reg <= half_end ? '0 : half_cnt_reg + HALF_CNT_W'(1);
      phase_reg <= phase_next;
    end
  end

  // debounce: sample on each complement rising edge, take a level only
  // when all recent samples agree, so a short glitch never starts a stop
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      samp_reg <= {DEBOUNCE_EDGES{HALT_ACC_RST}};
      halt_acc_reg <= HALT_ACC_RST;
    end
    else if (comp_rise)
    begin
      samp_reg <= {samp_reg[DEBOUNCE_EDGES-2:0], output_halt_n};
      // new sample plus the previous ones must all match
      if (&{samp_reg[DEBOUNCE_EDGES-2:0], output_halt_n})
      begin
        halt_acc_reg <= 1'b1;
      end
      else if (~|{samp_reg[DEBOUNCE_EDGES-2:0], output_halt_n})
      begin
        halt_acc_reg <= 1'b0;
      end
    end
  end

  // fast drive-up in undriven park: the pin register reads output_halt_n
  // directly, so a parked true pin is driven high one clock (8 ns) after
  // the release; any extra register stage would push it past the limit
  // hazard: the pin follows the raw input, so a short high pulse shows as
  // a brief driven-high level on a parked true pin; only the debounced
  // level decides whether the pairs actually restart
  // this is the one place where the raw input reaches an output

  // halt sequencing shared by all stoppable pairs
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ST_RUN;
    end
    else
    begin
      unique case (state_reg)
        // running: wait for an accepted halt
        ST_RUN:
        begin
          if (!halt_acc_reg)
          begin
            state_reg <= ST_STOPPING;
          end
        end
        // finish the running cycle up to the true rising transition
        ST_STOPPING:
        begin
          if (rise_evt)
          begin
            state_reg <= ST_PARKED;
          end
        end
        // parked until the release is accepted
        ST_PARKED:
        begin
          if (halt_acc_reg)
          begin
            state_reg <= ST_RESTART;
          end
        end
        // wait, then resume on a true rising point so the high phase is whole
        ST_RESTART:
        begin
          if (!halt_acc_reg)
          begin
            state_reg <= ST_PARKED;
          end
          else if (restart_done && rise_evt)
          begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // restart delay in whole output periods, counted on complement edges
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      restart_cnt_reg <= RESTART_PERIODS;
    end
    else if (state_reg == ST_PARKED)
    begin
      restart_cnt_reg <= RESTART_PERIODS;
    end
    else if (state_reg == ST_RESTART && comp_rise && !restart_done)
    begin
      restart_cnt_reg <= restart_cnt_reg - 3'h1;
    end
  end

  // accepted halt level shown to the outside
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      halted <= 1'b0;
    end
    else
    begin
      halted <= !halt_acc_reg;
    end
  end

  // per pair output stage; all pairs share one state so they resume together
  for (genvar i = 0; i < NUM_PAIRS; i++)
  begin : g_pair
    logic parked; // this pair is held in its park state
    assign parked = pair_stoppable[i] &&
                    (state_reg == ST_PARKED || state_reg == ST_RESTART);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
      if (!arst_n)
      begin
        pair_pins[i] <= '0;
      end
      else if (!parked)
      begin
        // normal toggling; free-running pairs always land here
        pair_pins[i].true_o <= phase_next;
        pair_pins[i].true_oe <= 1'b1;
        pair_pins[i].comp_o <= ~phase_next;
        pair_pins[i].comp_oe <= 1'b1;
      end
      else if (park_mode == PARK_DRIVEN)
      begin
        // true held high at full drive, termination pulls complement low
        pair_pins[i].true_o <= 1'b1;
        pair_pins[i].true_oe <= 1'b1;
        pair_pins[i].comp_o <= 1'b0;
        pair_pins[i].comp_oe <= 1'b0;
      end
      else
      begin
        // undriven park; true is driven high again as soon as the raw
        // input releases, before the debounced restart completes
        pair_pins[i].true_o <= output_halt_n;
        pair_pins[i].true_oe <= output_halt_n;
        pair_pins[i].comp_o <= 1'b0;
        pair_pins[i].comp_oe <= 1'b0;
      end
    end
  end

endmodule : diff_output_stop_control

`default_nettype wire

// File: logic/halt_ctrl_pkg.sv
// shared constants and types for the differential output halt controller
// assumes one reference clock domain; output pairs are made from it
package halt_ctrl_pkg;

  // output clock half period in reference clock cycles (plain default)
  localparam int unsigned HALF_PERIOD_DEF = 2;
  // width of the half period counter
  localparam int unsigned HALF_CNT_W = 8;
  // number of output pairs in the device
  localparam int unsigned NUM_PAIRS_DEF = 4;
  // stable samples needed on complement rising edges before a level is taken
  localparam int unsigned DEBOUNCE_EDGES = 2;
  // output periods waited after an accepted release before resuming
  localparam logic [2:0] RESTART_PERIODS = 3'h2;
  // reset value of the accepted halt level (not halted)
  localparam logic HALT_ACC_RST = 1'b1;
  // parking drive modes
  localparam logic PARK_DRIVEN = 1'b0;
  localparam logic PARK_UNDRIVEN = 1'b1;

  // one output pair: values and enables of true and complement pins
  typedef struct packed {
    logic true_o;   // true pin value
    logic true_oe;  // true pin driven
    logic comp_o;   // complement pin value
    logic comp_oe;  // complement pin driven
  } clk_pair_pins_t;

  // global halt sequencing
  typedef enum logic [1:0] {
    ST_RUN,
    ST_STOPPING,
    ST_PARKED,
    ST_RESTART
  } halt_state_t;

endpackage : halt_ctrl_pkg

// File: verification/pair_termination.sv
// far side model: termination and receivers of the output pairs
// assumes undriven lines are pulled low by termination
`timescale 1ns/1ps
`default_nettype none
module pair_termination
  import halt_ctrl_pkg::*;
#(
  parameter int unsigned N = 4
)
(
  input wire clk_pair_pins_t [N-1:0] pins, // device pins
  output logic [N-1:0] line_true, // true line level
  output logic [N-1:0] line_comp // comp line level
);
  // released line falls to the pull-down level
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      line_true[i] = pins[i].true_oe & pins[i].true_o;
      line_comp[i] = pins[i].comp_oe & pins[i].comp_o;
    end
  end
endmodule : pair_termination
`default_nettype wire

// File: verification/stop_ctrl_checker.sv
// port checker for the halt controller
// assumes HALF_PERIOD of 2, so an output period of 4 clocks
`timescale 1ns/1ps
`default_nettype none
module stop_ctrl_checker
  import halt_ctrl_pkg::*;
#(
  parameter int unsigned NUM_PAIRS = NUM_PAIRS_DEF,
  parameter logic [HALF_CNT_W-1:0] HALF_PERIOD = HALF_CNT_W'(HALF_PERIOD_DEF)
)
(
  input wire logic clk_sys, // clock
  input wire logic arst_n, // reset
  input wire logic output_halt_n, // halt request
  input wire logic park_mode, // park mode
  input wire logic [NUM_PAIRS-1:0] pair_stoppable, // pair settings
  input wire clk_pair_pins_t [NUM_PAIRS-1:0] pair_pins, // pins
  input wire logic halted // halt level
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // consecutive cycles the halt input has held low or high, saturating;
  // long holds are counted here instead of unrolled repetitions
  logic [3:0] low_run_reg; // cycles held low
  logic [3:0] high_run_reg; // cycles held high
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_run_reg <= 4'h0;
      high_run_reg <= 4'h0;
    end
    else
    begin
      if (output_halt_n)
        low_run_reg <= 4'h0;
      else if (low_run_reg != 4'hF)
        low_run_reg <= low_run_reg + 4'h1;
      if (!output_halt_n)
        high_run_reg <= 4'h0;
      else if (high_run_reg != 4'hF)
        high_run_reg <= high_run_reg + 4'h1;
    end
  end
  // long enough for stopping to be over
  sequence s_parked;
    halted[*8];
  endsequence
  a_free_run: assert property ($past(arst_n) && !$past(pair_stoppable[0]) |->
    pair_pins[0].true_oe &&
    pair_pins[0].comp_oe && pair_pins[0].comp_o != pair_pins[0].true_o) else $error("free stop");
  a_park_driven: assert property ($rose(halted) && !park_mode && pair_stoppable[1] |->
    ##[1:6] (pair_pins[1] == 4'hC)[*8]) else $error("driven park");
  a_park_undriven: assert property ($rose(halted) && park_mode && pair_stoppable[1] |->
    ##[1:6] (pair_pins[1] == 4'h0)[*4]) else $error("undriven park");
  a_drive_up: assert property (s_parked ##0 park_mode && pair_stoppable[1] &&
    $rose(output_halt_n) |-> ##1 pair_pins[1].true_o && pair_pins[1].true_oe) else $error("up");
  a_halt_accept: assert property (!output_halt_n && low_run_reg >= 4'h9 |-> ##[0:2] halted)
    else $error("halt not taken");
  a_release_accept: assert property (output_halt_n && high_run_reg >= 4'h9 |-> ##[0:2] !halted)
    else $error("release not taken");
  a_no_runt: assert property ($changed(pair_pins[1].true_o) && pair_pins[1].true_oe |=>
    $stable(pair_pins[1].true_o) || !pair_pins[1].true_oe) else $error("runt pulse");
  a_restart_window: assert property (s_parked ##0 !park_mode && pair_stoppable[1] &&
    $rose(output_halt_n) |-> pair_pins[1].true_o[*8] ##[1:16] !pair_pins[1].true_o)
    else $error("restart latency");
  a_pairs_together: assert property (pair_stoppable[2:1] == 2'h3 |->
    pair_pins[1] == pair_pins[2]) else $error("pairs apart");
endmodule : stop_ctrl_checker
bind diff_output_stop_control stop_ctrl_checker #(.NUM_PAIRS(NUM_PAIRS),
  .HALF_PERIOD(HALF_PERIOD)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .output_halt_n(output_halt_n), .park_mode(park_mode), .pair_stoppable(pair_stoppable),
  .pair_pins(pair_pins), .halted(halted));
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the halt controller
// assumes the termination model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb;
  import halt_ctrl_pkg::*;
  typedef struct packed {logic mode; logic [3:0] stop; logic [3:0] exp;} row_t; // case
  logic clk_sys = 1'b0; // reference clock
  logic arst_n = 1'b0; // reset
  logic output_halt_n = 1'b1; // halt request
  logic park_mode = 1'b0; // park mode
  logic [3:0] pair_stoppable = 4'hE; // pair settings
  clk_pair_pins_t [3:0] pair_pins; // pins
  logic halted; // accepted halt
  logic [3:0] line_true; // true lines
  logic [3:0] line_comp; // comp lines
  logic v; // earlier level
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  row_t rows [4] = '{'{1'b0, 4'hE, 4'hC}, '{1'b1, 4'hE, 4'h0}, '{1'b0, 4'h2, 4'hC},
    '{1'b1, 4'hF, 4'h0}};
  diff_output_stop_control #(.NUM_PAIRS(4)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .output_halt_n(output_halt_n), .park_mode(park_mode), .pair_stoppable(pair_stoppable),
    .pair_pins(pair_pins), .halted(halted));
  pair_termination #(.N(4)) term (.pins(pair_pins), .line_true(line_true),
    .line_comp(line_comp));
  // reference clock never stops while halting
  initial forever #4 clk_sys = ~clk_sys;
  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // hang guard, well past the planned run
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  initial
  begin
    tick(19);
    #1;
    cmp(pair_pins[1], 4'h0);
    tick(1);
    arst_n <= 1'b1;
    foreach (rows[i])
    begin
      tick(1);
      park_mode <= rows[i].mode;
      pair_stoppable <= rows[i].stop;
      tick(4);
      output_halt_n <= 1'b0;
      tick(16);
      #1;
      cmp(pair_pins[1], rows[i].exp);
      cmp({3'h0, halted}, 4'h1);
      v = line_true[0];
      tick(2);
      #1;
      if (!rows[i].stop[0]) cmp({3'h0, line_true[0]}, {3'h0, ~v});
      tick(1);
      output_halt_n <= 1'b1;
      tick(1);
      #1;
      if (rows[i].mode) cmp({3'h0, line_true[1]}, 4'h1);
      tick(31);
      #1;
      cmp({3'h0, halted}, 4'h0);
      cmp({3'h0, line_comp[1]}, {3'h0, ~line_true[1]});
    end
    // short pulse seen on one complement edge only must be refused
    tick(1);
    output_halt_n <= 1'b0;
    tick(4);
    output_halt_n <= 1'b1;
    tick(1);
    #1;
    cmp({3'h0, halted}, 4'h0);
    tick(10);
    #1;
    cmp({3'h0, halted}, 4'h0);
    // halt again in mid restart
    tick(1);
    pair_stoppable <= 4'hE;
    output_halt_n <= 1'b0;
    tick(20);
    output_halt_n <= 1'b1;
    tick(10);
    output_halt_n <= 1'b0;
    tick(20);
    #1;
    cmp(pair_pins[3], 4'h0);
    // second reset while parked
    tick(1);
    arst_n <= 1'b0;
    tick(2);
    #1;
    cmp({3'h0, halted}, 4'h0);
    tick(1);
    output_halt_n <= 1'b1;
    arst_n <= 1'b1;
    tick(20);
    #1;
    cmp({3'h0, line_comp[2]}, {3'h0, ~line_true[2]});
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
